// [hw/t2rc_pkg.sv]
// constants for the third timer: register map, field positions, reset values
package t2rc_pkg;

  // ------------------------------------------------------------
  // register addresses
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_CONTROL       = 8'hc8;
  localparam logic [7:0] ADDR_RELOAD_LOW    = 8'hca;
  localparam logic [7:0] ADDR_RELOAD_HIGH   = 8'hcb;
  localparam logic [7:0] ADDR_COUNT_LOW     = 8'hcc;
  localparam logic [7:0] ADDR_COUNT_HIGH    = 8'hcd;
  localparam logic [7:0] ADDR_TIMER0_HIGH   = 8'h8c;

  // ------------------------------------------------------------
  // control register fields
  // ------------------------------------------------------------
  localparam int BIT_OVERFLOW_FLAG   = 7;
  localparam int BIT_EVENT_FLAG      = 6;
  localparam int BIT_RX_CLOCK_SOURCE = 5;
  localparam int BIT_TX_CLOCK_SOURCE = 4;
  localparam int BIT_TRIGGER_ENABLE  = 3;
  localparam int BIT_RUN             = 2;
  localparam int BIT_COUNTER_SELECT  = 1;
  localparam int BIT_CAPTURE_SELECT  = 0;

  // ------------------------------------------------------------
  // reset values and limits
  // ------------------------------------------------------------
  localparam logic [7:0]  RESET_BYTE  = 8'h00;
  localparam logic [15:0] RESET_WORD  = 16'h0000;
  localparam logic [15:0] COUNT_MAX   = 16'hffff;
  localparam logic [15:0] COUNT_STEP  = 16'h0001;
  localparam logic [7:0]  BYTE_MAX    = 8'hff;
  localparam logic [7:0]  BYTE_STEP   = 8'h01;

  typedef enum logic [1:0] {
    MODE_OFF,
    MODE_RELOAD,
    MODE_CAPTURE,
    MODE_BAUD
  } t2rc_mode_e;

endpackage

// [hw/t2rc_edge_if.sv]
// carrier between a pin and its falling-edge detector
`timescale 1ns/100ps
`default_nettype none
interface t2rc_edge_if;
  logic raw;
  logic fall;
  modport det  (input raw, output fall);
  modport user (output raw, input fall);
endinterface
`default_nettype wire

// [hw/t2rc_edge.sv]
// two-flop synchroniser with one-pulse falling-edge detect
`timescale 1ns/100ps
`default_nettype none
module t2rc_edge (
  input  wire logic   clock_i,  // core clock
  input  wire logic   srst_i,   // synchronous reset, high
  t2rc_edge_if.det    pin       // raw pin in, edge pulse out
);

  logic meta;
  logic sync;
  logic prev;
  logic fall;
  logic next_meta;
  logic next_sync;
  logic next_prev;
  logic next_fall;

  // ------------------------------------------------------------
  // next values
  // ------------------------------------------------------------
  always_comb begin
    next_meta = pin.raw;
    next_sync = meta;
    next_prev = sync;
    next_fall = prev & ~sync;
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      meta <= 1'b1;
      sync <= 1'b1;
      prev <= 1'b1;
      fall <= 1'b0;
    end else begin
      meta <= next_meta;
      sync <= next_sync;
      prev <= next_prev;
      fall <= next_fall;
    end
  end

  assign pin.fall = fall;

endmodule
`default_nettype wire

// [hw/t2rc_top.sv]
// third timer/counter with reload, capture, baud and split-timer support
`timescale 1ns/100ps
`default_nettype none
module t2rc_top (
  input  wire logic       clock_i,               // core clock, 40 MHz
  input  wire logic       srst_i,                // synchronous reset, high
  input  wire logic [7:0] sfr_addr_i,            // register address
  input  wire logic       sfr_wr_i,              // register write strobe
  input  wire logic [7:0] sfr_wdata_i,           // register write data
  output logic      [7:0] sfr_rdata_o,           // register read data
  input  wire logic       count_pin_i,           // external count pin
  input  wire logic       trigger_pin_i,         // external trigger pin
  input  wire logic       timer0_split_i,        // timer 0 in two-byte mode
  input  wire logic       timer1_run_i,          // timer 1 run bit
  input  wire logic       timer1_hold_i,         // timer 1 in its hold mode
  output logic            overflow_flag_o,       // overflow flag level
  output logic            event_flag_o,          // external event flag level
  output logic            baud_tick_o,           // baud rollover pulse
  output logic            timer1_overflow_set_o, // sets timer 1 flag, pulse
  output logic            timer1_count_en_o      // timer 1 may count
);

  logic [7:0]            control;
  logic [15:0]           count;
  logic [15:0]           reload;
  logic [7:0]            timer0_high;
  logic                  baud_tick;
  logic                  timer1_overflow_set;
  logic                  timer1_count_en;
  logic [7:0]            rdata;
  logic [7:0]            next_control;
  logic [15:0]           next_count;
  logic [15:0]           next_reload;
  logic [7:0]            next_timer0_high;
  logic                  next_baud_tick;
  logic                  next_timer1_overflow_set;
  logic                  next_timer1_count_en;
  logic [7:0]            next_rdata;
  t2rc_pkg::t2rc_mode_e  mode;
  logic                  tick;
  logic                  step;
  logic                  wrap;
  logic                  ext_event;
  logic                  set_overflow;
  logic                  set_event;

  // ------------------------------------------------------------
  // pin edge detectors
  // ------------------------------------------------------------
  t2rc_edge_if count_edge ();
  t2rc_edge_if trigger_edge ();

  assign count_edge.raw   = count_pin_i;
  assign trigger_edge.raw = trigger_pin_i;

  t2rc_edge u_count_edge (
    .clock_i (clock_i),
    .srst_i  (srst_i),
    .pin     (count_edge)
  );

  t2rc_edge u_trigger_edge (
    .clock_i (clock_i),
    .srst_i  (srst_i),
    .pin     (trigger_edge)
  );

  // ------------------------------------------------------------
  // mode decode
  // ------------------------------------------------------------
  always_comb begin
    if (!control[t2rc_pkg::BIT_RUN]) begin
      mode = t2rc_pkg::MODE_OFF;
    end else if (control[t2rc_pkg::BIT_RX_CLOCK_SOURCE] ||
                 control[t2rc_pkg::BIT_TX_CLOCK_SOURCE]) begin
      mode = t2rc_pkg::MODE_BAUD;
    end else if (control[t2rc_pkg::BIT_CAPTURE_SELECT]) begin
      mode = t2rc_pkg::MODE_CAPTURE;
    end else begin
      mode = t2rc_pkg::MODE_RELOAD;
    end
  end

  // ------------------------------------------------------------
  // next values
  // ------------------------------------------------------------
  always_comb begin
    next_control             = control;
    next_count               = count;
    next_reload              = reload;
    next_timer0_high         = timer0_high;
    next_baud_tick           = 1'b0;
    next_timer1_overflow_set = 1'b0;
    set_overflow             = 1'b0;
    set_event                = 1'b0;

    // count source: pin edges or every core clock
    tick = control[t2rc_pkg::BIT_COUNTER_SELECT] ?
           count_edge.fall : 1'b1;
    step = (mode != t2rc_pkg::MODE_OFF) && tick;
    wrap = step && (count == t2rc_pkg::COUNT_MAX);
    ext_event = (mode != t2rc_pkg::MODE_OFF) &&
                control[t2rc_pkg::BIT_TRIGGER_ENABLE] &&
                trigger_edge.fall;

    unique case (mode)
      t2rc_pkg::MODE_OFF: begin
      end
      t2rc_pkg::MODE_RELOAD: begin
        if (wrap || ext_event) begin
          next_count = reload;
        end else if (step) begin
          next_count = count + t2rc_pkg::COUNT_STEP;
        end
        set_overflow = wrap;
        set_event    = ext_event;
      end
      t2rc_pkg::MODE_CAPTURE: begin
        if (step) begin
          next_count = count + t2rc_pkg::COUNT_STEP;
        end
        if (ext_event) begin
          next_reload = count;
        end
        set_overflow = wrap;
        set_event    = ext_event;
      end
      t2rc_pkg::MODE_BAUD: begin
        if (wrap) begin
          next_count = reload;
        end else if (step) begin
          next_count = count + t2rc_pkg::COUNT_STEP;
        end
        next_baud_tick = wrap;
        set_event      = ext_event;
      end
    endcase

    // split timer 0 high byte runs under timer 1's run bit
    if (timer0_split_i && timer1_run_i) begin
      next_timer0_high = timer0_high + t2rc_pkg::BYTE_STEP;
      next_timer1_overflow_set =
        (timer0_high == t2rc_pkg::BYTE_MAX);
    end
    next_timer1_count_en = timer1_run_i && !timer1_hold_i;

    // software writes override the hardware update of data bytes
    if (sfr_wr_i) begin
      unique case (sfr_addr_i)
        t2rc_pkg::ADDR_CONTROL:     next_control       = sfr_wdata_i;
        t2rc_pkg::ADDR_RELOAD_LOW:  next_reload[7:0]   = sfr_wdata_i;
        t2rc_pkg::ADDR_RELOAD_HIGH: next_reload[15:8]  = sfr_wdata_i;
        t2rc_pkg::ADDR_COUNT_LOW:   next_count[7:0]    = sfr_wdata_i;
        t2rc_pkg::ADDR_COUNT_HIGH:  next_count[15:8]   = sfr_wdata_i;
        t2rc_pkg::ADDR_TIMER0_HIGH: next_timer0_high   = sfr_wdata_i;
        default: begin
        end
      endcase
    end

    // a flag set by hardware wins over a software clear
    if (set_overflow) begin
      next_control[t2rc_pkg::BIT_OVERFLOW_FLAG] = 1'b1;
    end
    if (set_event) begin
      next_control[t2rc_pkg::BIT_EVENT_FLAG] = 1'b1;
    end

    // read mux, registered one cycle behind the address
    unique case (sfr_addr_i)
      t2rc_pkg::ADDR_CONTROL:     next_rdata = control;
      t2rc_pkg::ADDR_RELOAD_LOW:  next_rdata = reload[7:0];
      t2rc_pkg::ADDR_RELOAD_HIGH: next_rdata = reload[15:8];
      t2rc_pkg::ADDR_COUNT_LOW:   next_rdata = count[7:0];
      t2rc_pkg::ADDR_COUNT_HIGH:  next_rdata = count[15:8];
      t2rc_pkg::ADDR_TIMER0_HIGH: next_rdata = timer0_high;
      default:                    next_rdata = t2rc_pkg::RESET_BYTE;
    endcase
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      control             <= t2rc_pkg::RESET_BYTE;
      count               <= t2rc_pkg::RESET_WORD;
      reload              <= t2rc_pkg::RESET_WORD;
      timer0_high         <= t2rc_pkg::RESET_BYTE;
      baud_tick           <= 1'b0;
      timer1_overflow_set <= 1'b0;
      timer1_count_en     <= 1'b0;
      rdata               <= t2rc_pkg::RESET_BYTE;
    end else begin
      control             <= next_control;
      count               <= next_count;
      reload              <= next_reload;
      timer0_high         <= next_timer0_high;
      baud_tick           <= next_baud_tick;
      timer1_overflow_set <= next_timer1_overflow_set;
      timer1_count_en     <= next_timer1_count_en;
      rdata               <= next_rdata;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign sfr_rdata_o           = rdata;
  assign overflow_flag_o       = control[t2rc_pkg::BIT_OVERFLOW_FLAG];
  assign event_flag_o          = control[t2rc_pkg::BIT_EVENT_FLAG];
  assign baud_tick_o           = baud_tick;
  assign timer1_overflow_set_o = timer1_overflow_set;
  assign timer1_count_en_o     = timer1_count_en;

endmodule
`default_nettype wire

// [sim/t2rc_top_assertions.sv]
// concurrent checks on the third timer's top-level ports
`timescale 1ns/100ps
`default_nettype none
module t2rc_top_assertions (
  input wire logic       clock_i,               // core clock
  input wire logic       srst_i,                // sync reset, high
  input wire logic [7:0] sfr_addr_i,            // register address
  input wire logic       sfr_wr_i,              // write strobe
  input wire logic [7:0] sfr_wdata_i,           // write data
  input wire logic [7:0] sfr_rdata_o,           // read data
  input wire logic       count_pin_i,           // count pin
  input wire logic       trigger_pin_i,         // trigger pin
  input wire logic       timer0_split_i,        // timer 0 split
  input wire logic       timer1_run_i,          // timer 1 run
  input wire logic       timer1_hold_i,         // timer 1 hold
  input wire logic       overflow_flag_o,       // overflow flag
  input wire logic       event_flag_o,          // event flag
  input wire logic       baud_tick_o,           // baud pulse
  input wire logic       timer1_overflow_set_o, // timer 1 flag set
  input wire logic       timer1_count_en_o      // timer 1 enable
);
  logic [5:0] mode, next_mode;   // control bits 5..0 as written
  logic [2:0] age, next_age;     // cycles since trigger fell, saturating
  logic       trig_q, next_trig_q;
  logic       ctl_wr;
  assign ctl_wr = sfr_wr_i && sfr_addr_i == t2rc_pkg::ADDR_CONTROL;
  always_comb begin
    next_mode = ctl_wr ? sfr_wdata_i[5:0] : mode;
    next_trig_q = trigger_pin_i;
    next_age = (age == 3'h7) ? age : age + 3'h1;
    if (trig_q && !trigger_pin_i) begin
      next_age = 3'h0;
    end
  end
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      mode <= 6'h00;
      age <= 3'h7;
      trig_q <= 1'b1;
    end else begin
      mode <= next_mode;
      age <= next_age;
      trig_q <= next_trig_q;
    end
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);
  chk_unmapped_zero: assert property (
    !(sfr_addr_i inside {8'hc8, 8'hca, 8'hcb, 8'hcc, 8'hcd, 8'h8c})
    |=> sfr_rdata_o == 8'h00) else $error("unmapped read not zero");
  chk_ctrl_readback: assert property (
    sfr_addr_i == t2rc_pkg::ADDR_CONTROL |=> sfr_rdata_o ==
    {$past(overflow_flag_o), $past(event_flag_o), $past(mode)})
    else $error("control readback wrong");
  chk_off_no_flag: assert property (
    $rose(overflow_flag_o) && !$past(sfr_wr_i) |-> $past(mode[2]))
    else $error("overflow while stopped");
  chk_baud_no_ovf: assert property (
    $rose(overflow_flag_o) && !$past(sfr_wr_i) |-> !$past(|mode[5:4]))
    else $error("overflow flag in baud mode");
  chk_tick_baud_only: assert property (
    baud_tick_o |-> $past(mode[2]) && $past(|mode[5:4]))
    else $error("baud tick outside baud mode");
  chk_event_latency: assert property (
    $rose(event_flag_o) && !$past(sfr_wr_i) |-> age >= 3'h2 && age <= 3'h6)
    else $error("event flag not tied to trigger fall");
  chk_event_enable: assert property (
    $rose(event_flag_o) && !$past(sfr_wr_i) |-> $past(mode[3] & mode[2]))
    else $error("event flag without enable and run");
  chk_flags_sticky: assert property (
    $fell(overflow_flag_o) || $fell(event_flag_o) |-> $past(ctl_wr))
    else $error("flag cleared without control write");
  chk_t1_hold_stop: assert property (
    timer1_hold_i |=> !timer1_count_en_o) else $error("timer 1 not held");
  chk_t1_run_go: assert property (
    timer1_run_i && !timer1_hold_i |=> timer1_count_en_o)
    else $error("timer 1 not resumed");
  chk_t1_ovf_cause: assert property (
    timer1_overflow_set_o |-> $past(timer0_split_i) && $past(timer1_run_i)
    ##1 !timer1_overflow_set_o) else $error("split overflow without cause");
endmodule
bind t2rc_top t2rc_top_assertions u_t2rc_top_assertions (.clock_i, .srst_i,
  .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i, .sfr_rdata_o, .count_pin_i,
  .trigger_pin_i, .timer0_split_i, .timer1_run_i, .timer1_hold_i,
  .overflow_flag_o, .event_flag_o, .baud_tick_o, .timer1_overflow_set_o,
  .timer1_count_en_o);
`default_nettype wire

// [sim/t2rc_pins.sv]
// model of the external count and trigger pins, pulled up when idle
`timescale 1ns/100ps
`default_nettype none
module t2rc_pins (
  input  wire logic clock_i,       // core clock
  output var  logic trigger_pin_o, // trigger pin
  output var  logic count_pin_o    // count pin
);
  initial begin
    trigger_pin_o = 1'b1;
    count_pin_o = 1'b1;
  end
  // one falling edge, low and high long enough for the synchroniser
  task automatic pulse(input logic trig);
    @(posedge clock_i);
    if (trig) begin
      trigger_pin_o <= 1'b0;
    end else begin
      count_pin_o <= 1'b0;
    end
    repeat (3) @(posedge clock_i);
    {trigger_pin_o, count_pin_o} <= 2'b11;
    repeat (4) @(posedge clock_i);
  endtask
endmodule
`default_nettype wire

// [sim/t2rc_top_tb.sv]
// self-checking bench for the third timer
`timescale 1ns/100ps
`default_nettype none
module t2rc_top_tb;
  localparam logic [7:0] CTL = t2rc_pkg::ADDR_CONTROL;
  localparam logic [7:0] RLD = t2rc_pkg::ADDR_RELOAD_LOW;
  localparam logic [7:0] CNT = t2rc_pkg::ADDR_COUNT_LOW;
  logic       clock_i, srst_i, sfr_wr_i, count_pin_i, trigger_pin_i;
  logic       timer0_split_i, timer1_run_i, timer1_hold_i;
  logic       overflow_flag_o, event_flag_o, baud_tick_o;
  logic       timer1_overflow_set_o, timer1_count_en_o;
  logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o;
  logic [7:0] regs [6];
  logic [7:0] bauds [2] = '{8'h10, 8'h20};
  int         mismatches, total_checks, cycles, ticks, t1ovf;
  t2rc_top u_t2rc_top (.clock_i, .srst_i, .sfr_addr_i, .sfr_wr_i,
    .sfr_wdata_i, .sfr_rdata_o, .count_pin_i, .trigger_pin_i,
    .timer0_split_i, .timer1_run_i, .timer1_hold_i, .overflow_flag_o,
    .event_flag_o, .baud_tick_o, .timer1_overflow_set_o,
    .timer1_count_en_o);
  t2rc_pins u_t2rc_pins (.clock_i, .trigger_pin_o(trigger_pin_i),
    .count_pin_o(count_pin_i));
  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge clock_i) begin
    cycles++;
    if (baud_tick_o === 1'b1) ticks++;
    if (timer1_overflow_set_o === 1'b1) t1ovf++;
    if (cycles == 4000) begin
      mismatches++;
      $display("[ERR] %0t timeout", $time);
      results();
    end
  end
  task automatic cmp(input logic [31:0] g, e, input string m);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %0t %s got %0h want %0h", $time, m, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge clock_i);
    sfr_addr_i <= a;
    sfr_wr_i <= 1'b1;
    sfr_wdata_i <= d;
    @(posedge clock_i);
    sfr_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, e);
    @(posedge clock_i);
    sfr_addr_i <= a;
    @(posedge clock_i);
    #1;
    cmp(sfr_rdata_o, e, $sformatf("read %h", a));
  endtask
  task automatic wr16(input logic [7:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a + 8'h01, v[15:8]);
  endtask
  task automatic rd16(input logic [7:0] a, input logic [15:0] e);
    rd(a, e[7:0]);
    rd(a + 8'h01, e[15:8]);
  endtask
  initial begin
    regs = '{CTL, RLD, RLD + 8'h01, CNT, CNT + 8'h01, 8'h8c};
    // split, hold, address and data stay open until first used;
    // timer 1 run low and write strobe low keep them from reaching any register
    srst_i = 1'b1;
    sfr_wr_i = 1'b0;
    timer1_run_i = 1'b0;
    repeat (2) @(posedge clock_i);
    srst_i <= 1'b0;
    foreach (regs[i]) rd(regs[i], 8'h00);
    foreach (regs[i]) wr(regs[i], 8'(8'h11 * (i + 1)));
    foreach (regs[i]) rd(regs[i], 8'(8'h11 * (i + 1)));
    rd(8'h55, 8'h00);
    $display("test registers done");
    wr16(RLD, 16'h1234);
    wr16(CNT, 16'hffff);
    wr(CTL, 8'h06);
    u_t2rc_pins.pulse(1'b0);
    rd16(CNT, 16'h1234);
    rd(CTL, 8'h86);
    cmp(overflow_flag_o, 1'b1, "overflow pin");
    wr(CTL, 8'h02);
    u_t2rc_pins.pulse(1'b0);
    rd16(CNT, 16'h1234);
    wr16(CNT, 16'h00fe);
    wr(CTL, 8'h06);
    repeat (3) u_t2rc_pins.pulse(1'b0);
    rd16(CNT, 16'h0101);
    wr16(CNT, 16'hffff);
    wr(CTL, 8'h07);
    u_t2rc_pins.pulse(1'b0);
    rd16(CNT, 16'h0000);
    rd16(RLD, 16'h1234);
    rd(CTL, 8'h87);
    wr(CTL, 8'h07);
    u_t2rc_pins.pulse(1'b1);
    rd(CTL, 8'h07);
    $display("test overflow done");
    wr16(RLD, 16'h5678);
    wr(CTL, 8'h0e);
    u_t2rc_pins.pulse(1'b1);
    rd16(CNT, 16'h5678);
    rd(CTL, 8'h4e);
    cmp(event_flag_o, 1'b1, "event pin");
    wr16(CNT, 16'habcd);
    wr(CTL, 8'h0f);
    u_t2rc_pins.pulse(1'b1);
    rd16(RLD, 16'habcd);
    rd16(CNT, 16'habcd);
    rd(CTL, 8'h4f);
    $display("test trigger done");
    foreach (bauds[i]) begin
      wr16(CNT, 16'hffff);
      wr(CTL, bauds[i] | 8'h0f);
      u_t2rc_pins.pulse(1'b0);
      rd16(CNT, 16'habcd);
      rd(CTL, bauds[i] | 8'h0f);
      u_t2rc_pins.pulse(1'b1);
      rd(CTL, bauds[i] | 8'h4f);
      rd16(RLD, 16'habcd);
    end
    cmp(ticks, 2, "baud ticks");
    $display("test baud done");
    wr(CTL, 8'h00);
    timer0_split_i <= 1'b1;
    timer1_run_i <= 1'b1;
    timer1_hold_i <= 1'b0;
    wr(8'h8c, 8'hf0);
    repeat (30) @(posedge clock_i);
    cmp(t1ovf, 1, "split wraps");
    timer1_hold_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    cmp(timer1_count_en_o, 0, "hold");
    timer1_hold_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    cmp(timer1_count_en_o, 1, "resume");
    timer1_run_i <= 1'b0;
    wr(8'h8c, 8'h40);
    rd(8'h8c, 8'h40);
    timer0_split_i <= 1'b0;
    timer1_run_i <= 1'b1;
    rd(8'h8c, 8'h40);
    $display("test split done");
    results();
  end
endmodule
`default_nettype wire
